// file: include/srch_pkg.sv
// constants, field layout and carrier types of the stream read command handler
// assumes one 100 MHz clock, registers reached over ahb-lite
// What this block does
// - command code 2bh written to the command register starts the stream read
// - transfer one to 65536 sectors; a count of zero means 65536
// - feature bit6 selects continuous read; cleared means ordinary streaming read
// - continuous read delivers the full length unless the time limit expires, and never sets the error status bit
// - continuous read sets stream error when any delivered sector had errors
// - continuous read never halts on read or transfer errors
// - errored continuous run ends busy clear, stream error set, error clear; kind logged
// - time limit expiry in continuous mode aborts; stream error set, log timeout flag set
// - every mode tries to move all data before the time limit passes
// - feature bit7 marks urgent; must finish within the time limit
// - time limit in us is upper feature byte times unit, counted from command write
// - on failure return lba of first bad sector, halves chosen by high byte select
package srch_pkg;
    localparam logic [7:0] SRCH_CMD_READ_STREAM = 8'h2b;
    localparam int SRCH_FEAT_URG_BIT = 7;
    localparam int SRCH_FEAT_RC_BIT = 6;
    // register byte offsets
    localparam logic [7:0] SRCH_A_FEAT = 8'h00;
    localparam logic [7:0] SRCH_A_CNT = 8'h04;
    localparam logic [7:0] SRCH_A_LBA_LO = 8'h08;
    localparam logic [7:0] SRCH_A_LBA_HI = 8'h0c;
    localparam logic [7:0] SRCH_A_CMD = 8'h10;
    localparam logic [7:0] SRCH_A_UNIT = 8'h14;
    localparam logic [7:0] SRCH_A_STATUS = 8'h18;
    localparam logic [7:0] SRCH_A_ERROR = 8'h1c;
    localparam logic [7:0] SRCH_A_LOG = 8'h20;
    localparam logic [7:0] SRCH_A_RESULT = 8'h24;
    localparam logic [7:0] SRCH_A_CTRL = 8'h28;
    localparam logic [7:0] SRCH_A_IRQ_ST = 8'h2c;
    localparam logic [7:0] SRCH_A_IRQ_MASK = 8'h30;
    // status and error bit positions
    localparam int SRCH_ST_BSY = 7;
    localparam int SRCH_ST_RDY = 6;
    localparam int SRCH_ST_SE = 5;
    localparam int SRCH_ST_DRQ = 3;
    localparam int SRCH_ST_ERR = 0;
    localparam int SRCH_ER_CRC = 7;
    localparam int SRCH_ER_UNC = 6;
    localparam int SRCH_ER_IDN = 4;
    localparam int SRCH_ER_ABT = 2;
    localparam int SRCH_ER_TIME_LIMIT_EXPIRED_FLAG = 0;
    // interrupt status bits
    localparam int SRCH_IRQ_DONE = 0;
    localparam int SRCH_IRQ_SE = 1;
    localparam int SRCH_IRQ_TO = 2;
    // status reset value and largest sector count
    localparam logic [7:0] SRCH_STATUS_RST = 8'h40;
    localparam logic [16:0] SRCH_MAX_SECTORS = 17'h10000;
    // time base
    localparam int SRCH_CLK_PERIOD_NS = 10;
    localparam int SRCH_US_NS = 1000;
    localparam int SRCH_CYC_PER_US = SRCH_US_NS / SRCH_CLK_PERIOD_NS;
    localparam logic [6:0] SRCH_PRE_LAST = 7'(SRCH_CYC_PER_US - 1);

    typedef enum logic [1:0] {
        SRCH_S_IDLE,
        SRCH_S_XFER
    } srch_state_t;

    // sector request toward the media engine
    typedef struct packed {
        logic valid;
        logic [47:0] lba;
    } srch_media_req_t;

    // per-sector answer: err = {crc, unc, idnf, abrt}
    typedef struct packed {
        logic done;
        logic [3:0] err;
    } srch_media_rsp_t;
endpackage : srch_pkg

// file: rtl/srch_core.sv
// stream read command handler: ahb-lite register slave, command fsm, time limit
// assumes a media engine answering one sector request at a time with a done pulse
//
// The placing of the registers and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module srch_core
    import srch_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic irq,
    output srch_media_req_t media_req,
    input wire srch_media_rsp_t media_rsp
);
    typedef struct packed {
        srch_state_t fsm;
        logic [15:0] feat;
        logic [15:0] cnt;
        logic [47:0] lba;
        logic [31:0] unit;
        logic high_byte_select;
        logic rc;
        logic urgent_request;
        logic [16:0] remain;
        logic [39:0] limit_us;
        logic [39:0] us;
        logic [6:0] pre;
        logic lim_on;
        logic [7:0] status;
        logic [7:0] error;
        logic [7:0] log;
        logic [47:0] bad_lba;
        logic bad_seen;
        logic [2:0] irq_st;
        logic [2:0] irq_mask;
        logic irq;
        logic [31:0] hrdata;
        logic wr_pend;
        logic [7:0] wr_addr;
        srch_media_req_t req;
    } srch_regs_t;

    srch_regs_t r_ff;
    srch_regs_t nxt_r;
    logic expired;
    logic [2:0] ev;

    function automatic logic [7:0] err_map(input logic [3:0] e);
        logic [7:0] m;
        m = 8'h00;
        m[SRCH_ER_CRC] = e[3];
        m[SRCH_ER_UNC] = e[2];
        m[SRCH_ER_IDN] = e[1];
        m[SRCH_ER_ABT] = e[0];
        return m;
    endfunction : err_map

    function automatic logic [16:0] sectors(input logic [15:0] c);
        return (c == 16'h0000) ? SRCH_MAX_SECTORS : {1'b0, c};
    endfunction : sectors

    function automatic logic [31:0] rd(input srch_regs_t s, input logic [7:0] a);
        case (a)
            SRCH_A_FEAT: rd = {16'h0000, s.feat};
            SRCH_A_CNT: rd = {16'h0000, s.cnt};
            SRCH_A_LBA_LO: rd = s.lba[31:0];
            SRCH_A_LBA_HI: rd = {16'h0000, s.lba[47:32]};
            SRCH_A_UNIT: rd = s.unit;
            SRCH_A_STATUS: rd = {24'h000000, s.status};
            SRCH_A_ERROR: rd = {24'h000000, s.error};
            SRCH_A_LOG: rd = {24'h000000, s.log};
            // selected halves of the first bad lba
            SRCH_A_RESULT: rd = s.high_byte_select ? {8'h00, s.bad_lba[47:24]} : {8'h00, s.bad_lba[23:0]};
            SRCH_A_CTRL: rd = {31'h00000000, s.high_byte_select};
            SRCH_A_IRQ_ST: rd = {29'h00000000, s.irq_st};
            SRCH_A_IRQ_MASK: rd = {29'h00000000, s.irq_mask};
            default: rd = 32'h00000000;
        endcase
    endfunction : rd

    // limit is ignored when the product is zero
    assign expired = r_ff.lim_on && (r_ff.us >= r_ff.limit_us);

    always_comb begin
        nxt_r = r_ff;
        ev = 3'h0;
        nxt_r.irq = |(r_ff.irq_st & r_ff.irq_mask);
        // data phase of a write
        if (r_ff.wr_pend) begin
            case (r_ff.wr_addr)
                SRCH_A_FEAT: nxt_r.feat = hwdata[15:0];
                SRCH_A_CNT: nxt_r.cnt = hwdata[15:0];
                SRCH_A_LBA_LO: nxt_r.lba[31:0] = hwdata;
                SRCH_A_LBA_HI: nxt_r.lba[47:32] = hwdata[15:0];
                SRCH_A_UNIT: nxt_r.unit = hwdata;
                SRCH_A_CTRL: nxt_r.high_byte_select = hwdata[0];
                SRCH_A_IRQ_ST: nxt_r.irq_st = r_ff.irq_st & ~hwdata[2:0];
                SRCH_A_IRQ_MASK: nxt_r.irq_mask = hwdata[2:0];
                SRCH_A_CMD: begin
                    if (r_ff.fsm == SRCH_S_IDLE && hwdata[7:0] == SRCH_CMD_READ_STREAM) begin
                        nxt_r.fsm = SRCH_S_XFER;
                        nxt_r.rc = r_ff.feat[SRCH_FEAT_RC_BIT];
                        nxt_r.urgent_request = r_ff.feat[SRCH_FEAT_URG_BIT];
                        nxt_r.remain = sectors(r_ff.cnt);
                        nxt_r.limit_us = 40'(r_ff.feat[15:8]) * 40'(r_ff.unit);
                        nxt_r.lim_on = (r_ff.feat[15:8] != 8'h00) && (r_ff.unit != 32'h0);
                        nxt_r.us = 40'h0;
                        nxt_r.pre = 7'h00;
                        nxt_r.status = 8'h00;
                        nxt_r.status[SRCH_ST_RDY] = 1'b1;
                        nxt_r.status[SRCH_ST_BSY] = 1'b1;
                        nxt_r.status[SRCH_ST_DRQ] = 1'b1;
                        nxt_r.error = 8'h00;
                        nxt_r.log = 8'h00;
                        nxt_r.bad_lba = 48'h0;
                        nxt_r.bad_seen = 1'b0;
                        nxt_r.req.valid = 1'b1;
                        nxt_r.req.lba = r_ff.lba;
                    end else if (r_ff.fsm == SRCH_S_IDLE) begin
                        // unknown command code is aborted
                        nxt_r.status[SRCH_ST_ERR] = 1'b1;
                        nxt_r.error = 8'h00;
                        nxt_r.error[SRCH_ER_ABT] = 1'b1;
                        ev[SRCH_IRQ_DONE] = 1'b1;
                    end
                end
                default: ;
            endcase
        end
        // address phase
        nxt_r.wr_pend = 1'b0;
        if (hsel && htrans[1] && hready) begin
            nxt_r.wr_pend = hwrite;
            nxt_r.wr_addr = haddr[7:0];
            if (!hwrite) begin
                // a write landing in this cycle is already seen by a back to back read
                nxt_r.hrdata = rd(nxt_r, haddr[7:0]);
            end
        end
        // command execution; time counted from the command write
        if (r_ff.fsm == SRCH_S_XFER) begin
            if (r_ff.pre == SRCH_PRE_LAST) begin
                nxt_r.pre = 7'h00;
                nxt_r.us = r_ff.us + 40'h1;
            end else begin
                nxt_r.pre = r_ff.pre + 7'h01;
            end
            if (expired) begin
                // urgent or not, the command never outlives its limit
                nxt_r.fsm = SRCH_S_IDLE;
                nxt_r.req.valid = 1'b0;
                nxt_r.status[SRCH_ST_BSY] = 1'b0;
                nxt_r.status[SRCH_ST_DRQ] = 1'b0;
                nxt_r.log[SRCH_ER_TIME_LIMIT_EXPIRED_FLAG] = 1'b1;
                if (r_ff.rc) begin
                    nxt_r.status[SRCH_ST_SE] = 1'b1;
                end else begin
                    nxt_r.status[SRCH_ST_ERR] = 1'b1;
                    nxt_r.error[SRCH_ER_TIME_LIMIT_EXPIRED_FLAG] = 1'b1;
                end
                ev[SRCH_IRQ_TO] = 1'b1;
                ev[SRCH_IRQ_DONE] = 1'b1;
                ev[SRCH_IRQ_SE] = r_ff.rc;
            end else if (r_ff.req.valid && media_rsp.done) begin
                if (|media_rsp.err) begin
                    nxt_r.log = r_ff.log | err_map(media_rsp.err);
                    if (!r_ff.bad_seen) begin
                        nxt_r.bad_lba = r_ff.req.lba;
                        nxt_r.bad_seen = 1'b1;
                    end
                end
                if ((|media_rsp.err) && !r_ff.rc) begin
                    nxt_r.fsm = SRCH_S_IDLE;
                    nxt_r.req.valid = 1'b0;
                    nxt_r.status[SRCH_ST_BSY] = 1'b0;
                    nxt_r.status[SRCH_ST_DRQ] = 1'b0;
                    nxt_r.status[SRCH_ST_ERR] = 1'b1;
                    nxt_r.error = err_map(media_rsp.err);
                    ev[SRCH_IRQ_DONE] = 1'b1;
                end else if (r_ff.remain == 17'h00001) begin
                    nxt_r.fsm = SRCH_S_IDLE;
                    nxt_r.req.valid = 1'b0;
                    nxt_r.status[SRCH_ST_BSY] = 1'b0;
                    nxt_r.status[SRCH_ST_DRQ] = 1'b0;
                    if (r_ff.bad_seen || (|media_rsp.err)) begin
                        nxt_r.status[SRCH_ST_SE] = 1'b1;
                        ev[SRCH_IRQ_SE] = 1'b1;
                    end
                    ev[SRCH_IRQ_DONE] = 1'b1;
                end else begin
                    // errors in continuous mode do not stop the run
                    nxt_r.remain = r_ff.remain - 17'h00001;
                    nxt_r.req.lba = r_ff.req.lba + 48'h1;
                end
            end
        end
        // hardware set wins over a software clear in the same cycle
        nxt_r.irq_st = nxt_r.irq_st | ev;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r_ff <= '0;
            r_ff.fsm <= SRCH_S_IDLE;
            r_ff.status <= SRCH_STATUS_RST;
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign hrdata = r_ff.hrdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign irq = r_ff.irq;
    assign media_req = r_ff.req;

    sequence cmd_write_s;
        r_ff.wr_pend && r_ff.wr_addr == SRCH_A_CMD && hwdata[7:0] == SRCH_CMD_READ_STREAM
            && r_ff.fsm == SRCH_S_IDLE;
    endsequence

    sequence last_sector_s;
        r_ff.fsm == SRCH_S_XFER && !expired && r_ff.req.valid && media_rsp.done && r_ff.remain == 17'h00001;
    endsequence

    start_on_cmd_a: assert property (@(posedge hclk) disable iff (!hresetn)
        cmd_write_s |=> r_ff.fsm == SRCH_S_XFER && media_req.valid && r_ff.status[SRCH_ST_BSY])
        else $error("command 2bh did not start a transfer");

    count_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
        cmd_write_s and (r_ff.cnt == 16'h0000) |=> r_ff.remain == SRCH_MAX_SECTORS)
        else $error("zero count did not mean 65536 sectors");

    rc_no_err_a: assert property (@(posedge hclk) disable iff (!hresetn)
        r_ff.fsm == SRCH_S_XFER && r_ff.rc |=> !r_ff.status[SRCH_ST_ERR])
        else $error("error status bit set in continuous mode");

    rc_keeps_going_a: assert property (@(posedge hclk) disable iff (!hresetn)
        r_ff.fsm == SRCH_S_XFER && r_ff.rc && !expired && media_rsp.done && (|media_rsp.err)
        && r_ff.remain > 17'h00001 |=> r_ff.fsm == SRCH_S_XFER && r_ff.remain == $past(r_ff.remain) - 17'h00001)
        else $error("continuous run stopped on an error");

    rc_se_end_a: assert property (@(posedge hclk) disable iff (!hresetn)
        last_sector_s and (r_ff.rc && (r_ff.bad_seen || (|media_rsp.err)))
        |=> r_ff.status[SRCH_ST_SE] && !r_ff.status[SRCH_ST_ERR] && !r_ff.status[SRCH_ST_BSY])
        else $error("errored continuous run ended without stream error");

    timeout_a: assert property (@(posedge hclk) disable iff (!hresetn)
        r_ff.fsm == SRCH_S_XFER && r_ff.rc && expired
        |=> r_ff.fsm == SRCH_S_IDLE && r_ff.status[SRCH_ST_SE] && r_ff.log[SRCH_ER_TIME_LIMIT_EXPIRED_FLAG] && !media_req.valid)
        else $error("time limit expiry not reported");

    normal_err_a: assert property (@(posedge hclk) disable iff (!hresetn)
        r_ff.fsm == SRCH_S_XFER && !r_ff.rc && !expired && media_rsp.done && (|media_rsp.err)
        |=> r_ff.status[SRCH_ST_ERR] && r_ff.error == err_map($past(media_rsp.err)) ##1 r_ff.fsm == SRCH_S_IDLE)
        else $error("ordinary mode error did not end the command");

    bad_lba_a: assert property (@(posedge hclk) disable iff (!hresetn)
        r_ff.fsm == SRCH_S_XFER && !expired && media_rsp.done && (|media_rsp.err) && !r_ff.bad_seen
        |=> r_ff.bad_lba == $past(media_req.lba))
        else $error("first bad lba not captured");

    limit_a: assert property (@(posedge hclk) disable iff (!hresetn)
        r_ff.fsm == SRCH_S_XFER && r_ff.lim_on && r_ff.us > r_ff.limit_us |-> 1'b0)
        else $error("command outlived its time limit");

    sequence cmd_end_s;
        r_ff.fsm == SRCH_S_XFER ##1 r_ff.fsm == SRCH_S_IDLE;
    endsequence

    rc_sel_a: assert property (@(posedge hclk) disable iff (!hresetn)
        cmd_write_s |=> r_ff.rc == $past(r_ff.feat[SRCH_FEAT_RC_BIT]))
        else $error("continuous read select not taken from feature bit6");

    urg_sel_a: assert property (@(posedge hclk) disable iff (!hresetn)
        cmd_write_s |=> r_ff.urgent_request == $past(r_ff.feat[SRCH_FEAT_URG_BIT]))
        else $error("urgent flag not taken from feature bit7");

    limit_start_a: assert property (@(posedge hclk) disable iff (!hresetn)
        cmd_write_s |=> r_ff.us == 40'h0 && r_ff.pre == 7'h00
        && r_ff.limit_us == 40'($past(r_ff.feat[15:8])) * 40'($past(r_ff.unit)))
        else $error("time limit not started at the command write");

    us_tick_a: assert property (@(posedge hclk) disable iff (!hresetn)
        r_ff.fsm == SRCH_S_XFER && r_ff.pre == SRCH_PRE_LAST |=> r_ff.us == $past(r_ff.us) + 40'h1)
        else $error("microsecond count did not advance");

    ord_timeout_a: assert property (@(posedge hclk) disable iff (!hresetn)
        r_ff.fsm == SRCH_S_XFER && !r_ff.rc && expired
        |=> r_ff.fsm == SRCH_S_IDLE && r_ff.status[SRCH_ST_ERR] && r_ff.error[SRCH_ER_TIME_LIMIT_EXPIRED_FLAG] && !media_req.valid)
        else $error("ordinary run outlived its time limit");

    end_status_a: assert property (@(posedge hclk) disable iff (!hresetn)
        cmd_end_s |-> r_ff.irq_st[SRCH_IRQ_DONE] && !r_ff.status[SRCH_ST_BSY] && !r_ff.status[SRCH_ST_DRQ])
        else $error("command end not reported");

    irq_on_a: assert property (@(posedge hclk) disable iff (!hresetn)
        |(r_ff.irq_st & r_ff.irq_mask) |=> irq)
        else $error("unmasked event did not raise the interrupt");

    irq_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !(|(r_ff.irq_st & r_ff.irq_mask)) |=> !irq)
        else $error("interrupt high with no unmasked event");
endmodule : srch_core
`default_nettype wire

// file: test/srch_media_model.sv
// media engine model: answers each sector request of the core with a done pulse
// assumes srch_pkg and the core's media link timing (done taken with valid high)
`timescale 1ns/1ps
`default_nettype none
module srch_media_model
    import srch_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire srch_media_req_t media_req,
    input wire logic [1:0] gap,
    input wire logic [47:0] bad_lba,
    input wire logic [3:0] bad_err,
    output srch_media_rsp_t media_rsp
);
    logic [1:0] cnt;
    logic [47:0] ask_lba;

    // a done being taken now has already moved the core on to the next sector
    assign ask_lba = media_rsp.done ? media_req.lba + 48'h1 : media_req.lba;

    // gap 0 answers every cycle, otherwise one done per gap+1 cycles at most
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            media_rsp <= '0;
            cnt <= 2'h0;
        end else begin
            media_rsp.done <= 1'b0;
            // error lines are junk outside a done pulse
            media_rsp.err <= ~media_rsp.err;
            cnt <= cnt + 2'h1;
            if (media_req.valid && (gap == 2'h0 || (!media_rsp.done && cnt >= gap))) begin
                media_rsp.done <= 1'b1;
                media_rsp.err <= (ask_lba == bad_lba) ? bad_err : 4'h0;
                cnt <= 2'h0;
            end
        end
    end
endmodule : srch_media_model
`default_nettype wire

// file: test/stream_read_command_handler_tb_top.sv
// self-checking bench of the stream read command handler
// assumes srch_pkg, srch_core and srch_media_model compiled first
`timescale 1ns/1ps
`default_nettype none
module stream_read_command_handler_tb_top;
    import srch_pkg::*;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans, gap;
    logic [47:0] bad_lba, nxt_lba, lba;
    logic [3:0] bad_err;
    srch_media_req_t media_req;
    srch_media_rsp_t media_rsp;
    logic [31:0] exp_q[$];
    logic rd_pend = 1'b0;
    int err_total, check_count, cyc, t0, el, sect_n;
    assign hready = hreadyout;

    srch_core DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .irq(irq), .media_req(media_req), .media_rsp(media_rsp));
    srch_media_model media (.hclk(hclk), .hresetn(hresetn), .media_req(media_req), .gap(gap),
        .bad_lba(bad_lba), .bad_err(bad_err), .media_rsp(media_rsp));

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_sim

    // one single transfer; on a read d is the expected word
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        if (!w) exp_q.push_back(d);
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= w ? d : ~hwdata;
        do @(posedge hclk); while (hready !== 1'b1);
    endtask : bus

    // loads the command block, issues the stream read and waits for its end
    task automatic start(input logic [15:0] feat, input logic [15:0] cnt, input logic [16:0] off);
        lba = 48'({$urandom(), $urandom()});
        bad_lba <= lba + 48'(off);
        bus(1'b1, SRCH_A_FEAT, {16'h0, feat});
        bus(1'b1, SRCH_A_CNT, {16'h0, cnt});
        bus(1'b1, SRCH_A_LBA_LO, lba[31:0]);
        bus(1'b1, SRCH_A_LBA_HI, {16'h0, lba[47:32]});
        sect_n = 0;
        nxt_lba = lba;
        t0 = cyc;
        bus(1'b1, SRCH_A_CMD, {24'h0, SRCH_CMD_READ_STREAM});
        repeat (2) @(posedge hclk);
        while (media_req.valid !== 1'b0) @(posedge hclk);
        el = cyc - t0;
        repeat (3) @(posedge hclk);
    endtask : start

    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    // read data, sector order and the run time limit
    always @(posedge hclk) begin
        cyc++;
        if (rd_pend && hready) chk(hrdata, exp_q.pop_front());
        if (rd_pend && hready) chk(hresp, 1'b0);
        rd_pend = hsel && htrans[1] && !hwrite && hready;
        if (media_req.valid && media_rsp.done) begin
            chk(media_req.lba, nxt_lba);
            nxt_lba++;
            sect_n++;
        end
        if (cyc == 95000) begin
            err_total++;
            end_sim();
        end
    end

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        gap = 2'h1;
        bad_lba = '1;
        bad_err = 4'h0;
        void'($urandom(31607));
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        bus(1'b0, SRCH_A_STATUS, 32'h40);
        bus(1'b0, 8'h3c, 32'h0);
        bus(1'b1, SRCH_A_CMD, 32'h25);
        bus(1'b0, SRCH_A_STATUS, 32'h41);
        bus(1'b0, SRCH_A_ERROR, 32'h04);
        bus(1'b1, SRCH_A_IRQ_ST, 32'h7);
        gap <= 2'($urandom_range(1, 3));
        start(16'h0000, 16'h0003, 17'h1ffff);
        chk(sect_n, 3);
        chk(irq, 1'b0);
        bus(1'b0, SRCH_A_STATUS, 32'h40);
        bus(1'b0, SRCH_A_IRQ_ST, 32'h1);
        bus(1'b1, SRCH_A_IRQ_MASK, 32'h7);
        repeat (3) @(posedge hclk);
        chk(irq, 1'b1);
        bus(1'b1, SRCH_A_IRQ_ST, 32'h7);
        repeat (3) @(posedge hclk);
        chk(irq, 1'b0);
        bus(1'b0, SRCH_A_IRQ_ST, 32'h0);
        gap <= 2'($urandom_range(1, 3));
        bad_err <= 4'h8;
        start(16'h0040, 16'h0004, 17'h1);
        chk(sect_n, 4);
        bus(1'b0, SRCH_A_STATUS, 32'h60);
        bus(1'b0, SRCH_A_ERROR, 32'h0);
        bus(1'b0, SRCH_A_LOG, 32'h80);
        bad_err <= 4'h4;
        start(16'h0000, 16'h0005, 17'h2);
        chk(sect_n, 3);
        bus(1'b0, SRCH_A_STATUS, 32'h41);
        bus(1'b0, SRCH_A_ERROR, 32'h40);
        bus(1'b0, SRCH_A_RESULT, {8'h0, bad_lba[23:0]});
        bus(1'b1, SRCH_A_CTRL, 32'h1);
        bus(1'b0, SRCH_A_RESULT, {8'h0, bad_lba[47:24]});
        bus(1'b1, SRCH_A_CTRL, 32'h0);
        gap <= 2'h3;
        bad_err <= 4'h0;
        bus(1'b1, SRCH_A_UNIT, 32'h1);
        start(16'h03c0, 16'd1000, 17'h1ffff);
        chk(el >= 300 && el <= 310, 1'b1);
        bus(1'b0, SRCH_A_STATUS, 32'h60);
        bus(1'b0, SRCH_A_ERROR, 32'h0);
        bus(1'b0, SRCH_A_LOG, 32'h01);
        bus(1'b0, SRCH_A_IRQ_ST, 32'h7);
        start(16'h0200, 16'd1000, 17'h1ffff);
        chk(el >= 200 && el <= 210, 1'b1);
        bus(1'b0, SRCH_A_STATUS, 32'h41);
        bus(1'b0, SRCH_A_ERROR, 32'h01);
        bus(1'b0, SRCH_A_LOG, 32'h01);
        bus(1'b1, SRCH_A_UNIT, 32'h0);
        gap <= 2'h0;
        start(16'h0000, 16'h0000, 17'h1ffff);
        chk(sect_n, 65536);
        bus(1'b0, SRCH_A_STATUS, 32'h40);
        end_sim();
    end
endmodule : stream_read_command_handler_tb_top
`default_nettype wire
